// ===== rtl/shw_walker.sv
/*
 shw_walker: walks submessage headers of one message and reports each span.
 assumes: upstream presents octets with valid/ready and the total length
 before the first octet; downstream takes sub_valid pulses with no stall.
*/
`timescale 1ns/1ps
`default_nettype none
module shw_walker
   import shw_pkg::*;
#(
   parameter int MSG_HDR_OCTETS = SHW_MSG_HDR_OCTETS,
   parameter int LEN_W = SHW_LEN_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic msg_start,
   input wire logic [LEN_W-1:0] msg_len,
   input wire logic [7:0] octet_data,
   input wire logic octet_valid,
   output logic octet_ready,
   output logic sub_valid,
   output logic [7:0] sub_kind_code,
   output logic [7:0] sub_flags,
   output logic byte_order_flag,
   output shw_class_t sub_class,
   output logic sub_known,
   output logic [15:0] sub_span_len,
   output logic [LEN_W-1:0] sub_body_start,
   output logic [LEN_W-1:0] sub_body_len,
   output logic sub_last,
   output logic malformed,
   output logic msg_done
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [2:0] {
      SHW_IDLE,
      SHW_SKIP,
      SHW_KIND,
      SHW_FLAGS,
      SHW_LEN0,
      SHW_LEN1,
      SHW_BODY
   } shw_state_t;

   shw_state_t state_q, state_d;
   logic [LEN_W-1:0] pos_q, pos_d;
   logic [LEN_W-1:0] total_q;
   logic [LEN_W-1:0] next_q, next_d;
   logic [7:0] kind_q, flags_q, len0_q;
   // kind is copied at header end so it stands as long as the other fields
   logic [7:0] kind_hold_q;
   logic valid_q, last_q, bad_q, done_q;
   logic [7:0] kflags_q;
   shw_class_t class_q;
   logic known_q;
   logic [15:0] span_q;
   logic [LEN_W-1:0] bstart_q, blen_q;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   shw_class_t dec_class;
   logic dec_known, dec_chain;
   logic [7:0] dec_flags;
   logic [15:0] dec_len;

   shw_kind_decode u_dec (
      .sub_kind_code(kind_q),
      .flags(flags_q),
      .kind_class(dec_class),
      .known_kind(dec_known),
      .zero_len_chain(dec_chain),
      .kind_flags(dec_flags)
   );

   wire logic order_bit = |(flags_q & SHW_BYTE_ORDER_MASK);

   shw_len_order u_len (
      .first_octet(len0_q),
      .second_octet(octet_data),
      .byte_order_flag(order_bit),
      .sub_span_len(dec_len)
   );

   wire logic take = clk_en && octet_valid && octet_ready;
   wire logic [LEN_W-1:0] pos_inc = pos_q + LEN_W'(1);
   wire logic [LEN_W-1:0] remain = total_q - pos_inc; // body octets left after header
   wire logic [LEN_W-1:0] len_ext = LEN_W'(dec_len);
   wire logic len_zero = (dec_len == 16'h0000);
   wire logic span_over = len_ext > remain;
   wire logic at_end = (len_ext == remain) || (len_zero && !dec_chain) ||
                       (len_zero && dec_chain && remain == '0);
   wire logic [LEN_W-1:0] body_len = (len_zero && !dec_chain) ? remain : len_ext;
   wire logic hdr_done = take && state_q == SHW_LEN1;

   assign octet_ready = state_q != SHW_IDLE;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      pos_d = take ? pos_inc : pos_q;
      next_d = next_q;
      case (state_q)
         SHW_IDLE: begin
            if (msg_start) begin
               pos_d = '0;
               state_d = (MSG_HDR_OCTETS == 0) ? SHW_KIND : SHW_SKIP;
            end
         end
         SHW_SKIP: begin
            if (take && pos_inc == LEN_W'(MSG_HDR_OCTETS)) begin
               state_d = SHW_KIND;
            end
         end
         SHW_KIND: begin
            if (take) begin
               state_d = SHW_FLAGS;
            end
         end
         SHW_FLAGS: begin
            if (take) begin
               state_d = SHW_LEN0;
            end
         end
         SHW_LEN0: begin
            if (take) begin
               state_d = SHW_LEN1;
            end
         end
         SHW_LEN1: begin
            if (take) begin
               next_d = pos_inc + body_len;
               if (span_over || at_end) begin
                  state_d = SHW_IDLE;
               end else if (len_zero) begin
                  state_d = SHW_KIND;
               end else begin
                  state_d = SHW_BODY;
               end
            end
         end
         SHW_BODY: begin
            if (take && pos_inc == next_q) begin
               state_d = SHW_KIND;
            end
         end
         default: begin
            state_d = SHW_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= SHW_IDLE;
         pos_q <= '0;
         next_q <= '0;
         total_q <= '0;
         kind_q <= 8'h00;
         flags_q <= 8'h00;
         len0_q <= 8'h00;
      end else if (clk_en) begin
         state_q <= state_d;
         pos_q <= pos_d;
         next_q <= next_d;
         if (state_q == SHW_IDLE && msg_start) begin
            total_q <= msg_len;
         end
         if (take && state_q == SHW_KIND) begin
            kind_q <= octet_data;
         end
         if (take && state_q == SHW_FLAGS) begin
            flags_q <= octet_data;
         end
         if (take && state_q == SHW_LEN0) begin
            len0_q <= octet_data;
         end
      end
   end

   // report is held until the next header completes; valid pulses once
   always_ff @(posedge clk) begin
      if (srst) begin
         valid_q <= 1'b0;
         last_q <= 1'b0;
         bad_q <= 1'b0;
         done_q <= 1'b0;
         kflags_q <= 8'h00;
         kind_hold_q <= 8'h00;
         class_q <= SHW_CLS_PROTO;
         known_q <= 1'b0;
         span_q <= 16'h0000;
         bstart_q <= '0;
         blen_q <= '0;
      end else if (clk_en) begin
         valid_q <= hdr_done && !span_over;
         done_q <= hdr_done && (span_over || at_end);
         if (state_q == SHW_IDLE && msg_start) begin
            bad_q <= 1'b0;
         end else if (hdr_done && span_over) begin
            bad_q <= 1'b1;
         end
         if (hdr_done) begin
            last_q <= at_end && !span_over;
            kflags_q <= dec_flags | (flags_q & SHW_BYTE_ORDER_MASK);
            kind_hold_q <= kind_q;
            class_q <= dec_class;
            known_q <= dec_known;
            span_q <= dec_len;
            bstart_q <= pos_inc;
            blen_q <= body_len;
         end
      end
   end

   assign sub_valid = valid_q;
   assign sub_kind_code = kind_hold_q;
   assign sub_flags = kflags_q;
   assign byte_order_flag = kflags_q[0];
   assign sub_class = class_q;
   assign sub_known = known_q;
   assign sub_span_len = span_q;
   assign sub_body_start = bstart_q;
   assign sub_body_len = blen_q;
   assign sub_last = last_q;
   assign malformed = bad_q;
   assign msg_done = done_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_len_taken;
      clk_en && state_q == SHW_LEN1 && take;
   endsequence

   // a header that fits the message; an overrun reports nothing
   sequence s_hdr_accept;
      s_len_taken ##0 !span_over;
   endsequence

   sequence s_body_exit;
      clk_en && state_q == SHW_BODY && take;
   endsequence

   a_vendor_class: assert property (s_hdr_accept ##0 kind_q[7]
      |=> sub_valid && sub_class == SHW_CLS_VENDOR)
      else $error("vendor kind not classified vendor");
   a_secure_class: assert property (s_hdr_accept ##0 (kind_q >= SHW_SECURE_FIRST &&
      kind_q <= SHW_SECURE_LAST) |=> sub_class == SHW_CLS_RESERVED)
      else $error("reserved kind misclassified");
   a_order_flag: assert property (sub_valid |-> byte_order_flag == $past(flags_q[0], 1))
      else $error("byte order flag mismatch");
   a_len_order: assert property (s_len_taken |=> sub_valid -> sub_span_len ==
      ($past(flags_q[0]) ? {$past(octet_data), $past(len0_q)}
                         : {$past(len0_q), $past(octet_data)}))
      else $error("span length byte order wrong");
   a_over_malformed: assert property (s_len_taken ##0 span_over
      |=> malformed && msg_done && state_q == SHW_IDLE)
      else $error("overrun not flagged");
   a_zero_last: assert property (s_len_taken ##0 (len_zero && !dec_chain)
      |=> sub_last && sub_body_len == $past(remain))
      else $error("zero length not last");
   a_pad_chain: assert property (s_len_taken ##0 (len_zero && dec_chain && remain != '0)
      |=> state_q == SHW_KIND && !sub_last)
      else $error("zero length padding did not chain");
   a_unused_flags: assert property (sub_valid && sub_kind_code == SHW_GAP_KIND
      |-> sub_flags[7:1] == 7'h00)
      else $error("unused flag bits passed");
   a_proto_class: assert property (sub_valid && sub_known |-> sub_class == SHW_CLS_PROTO)
      else $error("known kind not protocol class");
   a_chain_body: assert property (s_len_taken ##0 (len_zero && dec_chain)
      |=> sub_body_len == '0)
      else $error("zero length padding has a body");
   a_body_start: assert property (s_hdr_accept |=> sub_body_start == pos_q)
      else $error("body start not at first content octet");
   // the next header must land exactly where the reported body ends
   a_body_exit: assert property (s_body_exit ##0
      (pos_inc == sub_body_start + sub_body_len) |=> state_q == SHW_KIND)
      else $error("next header not found after body");
   a_body_stay: assert property (s_body_exit ##0
      (pos_inc != sub_body_start + sub_body_len) |=> state_q == SHW_BODY)
      else $error("body left early");
   a_last_done: assert property (sub_valid |-> msg_done == sub_last)
      else $error("last header and done disagree");
   // a frozen clock enable keeps the pulse up, so only enabled cycles count
   a_done_pulse: assert property (clk_en && msg_done |=> !msg_done)
      else $error("done held too long");
   a_skip_first: assert property (state_q == SHW_KIND |-> pos_q >= LEN_W'(MSG_HDR_OCTETS))
      else $error("kind read inside message header");
endmodule // shw_walker
`default_nettype wire

// ===== rtl/shw_pkg.sv
/*
 shw_pkg: constants and types shared by the submessage header walker.
 assumes: one 40 MHz clock, synchronous active-high reset, octet stream input.
*/
// Behaviour
// - header is kind, flags, 16-bit length
// - length byte order follows byte order flag
// - elements fill the span after header
// - kinds 0x00..0x7f are protocol-defined
// - kinds 0x80..0xff are vendor-specific, maker-dependent
// - recognise extension, padding, timestamp kinds
// - recognise remaining defined submessage kinds
// - kinds 0x30..0x3f reserved for security
// - flag bit zero is byte order flag
// - zero big-endian, one little-endian
// - other flag bits decoded per kind
// - unused flag bits ignored on receive
// - nonzero length gives next header offset
// - position versus total length decides last
// - zero length on other kinds means last
// - zero length padding/timestamp: next follows header
`default_nettype none
package shw_pkg;
   // ----------------------------------------
   // kind codes
   // ----------------------------------------
   localparam logic [7:0] SHW_HDR_EXTENSION_KIND = 8'h00;
   localparam logic [7:0] SHW_PADDING_KIND = 8'h01;
   localparam logic [7:0] SHW_ACK_NEGATIVE_KIND = 8'h06;
   localparam logic [7:0] SHW_LIVENESS_KIND = 8'h07;
   localparam logic [7:0] SHW_GAP_KIND = 8'h08;
   localparam logic [7:0] SHW_TIMESTAMP_INFO_KIND = 8'h09;
   localparam logic [7:0] SHW_SOURCE_INFO_KIND = 8'h0c;
   localparam logic [7:0] SHW_REPLY_V4_INFO_KIND = 8'h0d;
   localparam logic [7:0] SHW_DEST_INFO_KIND = 8'h0e;
   localparam logic [7:0] SHW_REPLY_INFO_KIND = 8'h0f;
   localparam logic [7:0] SHW_FRAG_NEGATIVE_KIND = 8'h12;
   localparam logic [7:0] SHW_FRAG_LIVENESS_KIND = 8'h13;
   localparam logic [7:0] SHW_SAMPLE_KIND = 8'h15;
   localparam logic [7:0] SHW_SAMPLE_FRAG_KIND = 8'h16;
   localparam logic [7:0] SHW_PROTO_LAST = 8'h7f;
   localparam logic [7:0] SHW_SECURE_FIRST = 8'h30;
   localparam logic [7:0] SHW_SECURE_LAST = 8'h3f;
   // ----------------------------------------
   // flag fields and sizes
   // ----------------------------------------
   localparam logic [7:0] SHW_BYTE_ORDER_MASK = 8'h01;
   localparam logic [7:0] SHW_EXT_FLAG_MASK = 8'hfe;
   localparam logic [7:0] SHW_ACK_FLAG_MASK = 8'h02;
   localparam logic [7:0] SHW_SAMPLE_FLAG_MASK = 8'h1e;
   localparam int SHW_MSG_HDR_OCTETS = 20;
   localparam int SHW_LEN_W = 20;
   // ----------------------------------------
   // classes
   // ----------------------------------------
   typedef enum logic [1:0] {
      SHW_CLS_PROTO,
      SHW_CLS_RESERVED,
      SHW_CLS_VENDOR,
      SHW_CLS_UNKNOWN
   } shw_class_t;
endpackage
`default_nettype wire

// ===== rtl/shw_kind_decode.sv
/*
 shw_kind_decode: classifies a kind code and masks its flags.
 assumes: combinational use inside the walker.
*/
`timescale 1ns/1ps
`default_nettype none
module shw_kind_decode
   import shw_pkg::*;
(
   input wire logic [7:0] sub_kind_code,
   input wire logic [7:0] flags,
   output shw_class_t kind_class,
   output logic known_kind,
   output logic zero_len_chain,
   output logic [7:0] kind_flags
);
   // ----------------------------------------
   // classification
   // ----------------------------------------
   wire logic is_vendor = sub_kind_code > SHW_PROTO_LAST;
   wire logic is_secure = (sub_kind_code >= SHW_SECURE_FIRST) &&
                          (sub_kind_code <= SHW_SECURE_LAST);
   wire logic is_pad_ts = (sub_kind_code == SHW_PADDING_KIND) ||
                          (sub_kind_code == SHW_TIMESTAMP_INFO_KIND);
   assign known_kind = (sub_kind_code == SHW_HDR_EXTENSION_KIND) || is_pad_ts ||
                       (sub_kind_code == SHW_ACK_NEGATIVE_KIND) ||
                       (sub_kind_code == SHW_LIVENESS_KIND) ||
                       (sub_kind_code == SHW_GAP_KIND) ||
                       (sub_kind_code == SHW_SOURCE_INFO_KIND) ||
                       (sub_kind_code == SHW_REPLY_V4_INFO_KIND) ||
                       (sub_kind_code == SHW_DEST_INFO_KIND) ||
                       (sub_kind_code == SHW_REPLY_INFO_KIND) ||
                       (sub_kind_code == SHW_FRAG_NEGATIVE_KIND) ||
                       (sub_kind_code == SHW_FRAG_LIVENESS_KIND) ||
                       (sub_kind_code == SHW_SAMPLE_KIND) ||
                       (sub_kind_code == SHW_SAMPLE_FRAG_KIND);
   assign kind_class = is_vendor ? SHW_CLS_VENDOR :
                       is_secure ? SHW_CLS_RESERVED :
                       known_kind ? SHW_CLS_PROTO : SHW_CLS_UNKNOWN;
   assign zero_len_chain = is_pad_ts;
   // ----------------------------------------
   // per-kind flag meaning; unused bits forced low
   // ----------------------------------------
   wire logic [7:0] kmask = (sub_kind_code == SHW_HDR_EXTENSION_KIND) ? SHW_EXT_FLAG_MASK :
                            (sub_kind_code == SHW_ACK_NEGATIVE_KIND) ? SHW_ACK_FLAG_MASK :
                            (sub_kind_code == SHW_SAMPLE_KIND) ? SHW_SAMPLE_FLAG_MASK :
                            (is_vendor ? ~SHW_BYTE_ORDER_MASK : 8'h00);
   assign kind_flags = flags & kmask;
endmodule // shw_kind_decode
`default_nettype wire

// ===== rtl/shw_len_order.sv
/*
 shw_len_order: assembles the 16-bit length by the byte order flag.
 assumes: octets given in wire order.
*/
`timescale 1ns/1ps
`default_nettype none
module shw_len_order
   import shw_pkg::*;
(
   input wire logic [7:0] first_octet,
   input wire logic [7:0] second_octet,
   input wire logic byte_order_flag,
   output logic [15:0] sub_span_len
);
   assign sub_span_len = byte_order_flag ? {second_octet, first_octet} :
                                           {first_octet, second_octet};
endmodule // shw_len_order
`default_nettype wire

// ===== verif/shw_octet_source.sv
/*
 shw_octet_source: upstream octet source model feeding the walker.
 assumes: bench pushes whole messages; same clock as the walker.
*/
`timescale 1ns/1ps
`default_nettype none
module shw_octet_source (
   input wire logic clk,
   input wire logic clk_en,
   input wire logic slow,
   input wire logic octet_ready,
   input wire logic msg_done,
   output logic [7:0] octet_data,
   output logic octet_valid
);
   logic [7:0] q[$];
   logic took = 1'b0;
   logic flush = 1'b0;
   logic phase = 1'b0;
   initial begin
      octet_data = 8'h00;
      octet_valid = 1'b0;
   end
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   // ----------------------------------------
   // delivery
   // ----------------------------------------
   always @(posedge clk) begin
      took = octet_valid & octet_ready & clk_en;
      flush = msg_done;
   end
   // trailing body octets of a last submessage are dropped, the walker is idle by then
   always @(negedge clk) begin
      phase = ~phase;
      if (flush) q.delete();
      else if (took) void'(q.pop_front());
      // an offered octet stays up until it is taken or the queue is flushed
      if (!(octet_valid && !took && !flush)) begin
         octet_valid = (q.size() > 0) && (!slow || phase);
      end
      // no stale value while idle: the line keeps changing
      octet_data = octet_valid ? q[0] : {phase, ~octet_data[6:0]};
   end
endmodule // shw_octet_source
`default_nettype wire

// ===== verif/shw_walker_bench.sv
/*
 shw_walker_bench: self-checking bench for the submessage header walker.
 assumes: shw_octet_source upstream; outputs sampled at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module shw_walker_bench;
   import shw_pkg::*;
   localparam int MH = 4;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic slow = 1'b0;
   logic freeze = 1'b0;
   logic msg_start = 1'b0;
   logic [19:0] msg_len = 20'h00000;
   logic [7:0] octet_data, sub_kind_code, sub_flags;
   logic octet_valid, octet_ready, sub_valid, byte_order_flag;
   logic sub_known, sub_last, malformed, msg_done;
   shw_class_t sub_class;
   logic [15:0] sub_span_len;
   logic [19:0] sub_body_start, sub_body_len;
   logic [79:0] got[$], want_q[$];
   logic [7:0] msg[$];
   int fails = 0;
   int samples_checked = 0;
   shw_walker #(.MSG_HDR_OCTETS(MH), .LEN_W(20)) dut (.clk(clk), .srst(srst),
      .clk_en(clk_en), .msg_start(msg_start), .msg_len(msg_len),
      .octet_data(octet_data), .octet_valid(octet_valid), .octet_ready(octet_ready),
      .sub_valid(sub_valid), .sub_kind_code(sub_kind_code), .sub_flags(sub_flags),
      .byte_order_flag(byte_order_flag), .sub_class(sub_class), .sub_known(sub_known),
      .sub_span_len(sub_span_len), .sub_body_start(sub_body_start),
      .sub_body_len(sub_body_len), .sub_last(sub_last), .malformed(malformed),
      .msg_done(msg_done));
   shw_octet_source src (.clk(clk), .clk_en(clk_en), .slow(slow),
      .octet_ready(octet_ready), .msg_done(msg_done), .octet_data(octet_data),
      .octet_valid(octet_valid));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) begin
      if (sub_valid === 1'b1) got.push_back({3'h0, sub_kind_code, sub_flags, byte_order_flag,
         sub_class, sub_known, sub_span_len, sub_body_start, sub_body_len, sub_last});
   end
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic known(input logic [7:0] k);
      return k inside {8'h00, 8'h01, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h0e,
         8'h0f, 8'h12, 8'h13, 8'h15, 8'h16};
   endfunction
   function automatic logic [7:0] fmask(input logic [7:0] k);
      case (k)
         8'h00: return 8'hff;
         8'h06: return 8'h03;
         8'h15: return 8'h1f;
         default: return (k >= 8'h80) ? 8'hff : 8'h01;
      endcase
   endfunction
   function automatic shw_class_t kcls(input logic [7:0] k);
      if (k >= 8'h80) return SHW_CLS_VENDOR;
      if (k >= 8'h30 && k <= 8'h3f) return SHW_CLS_RESERVED;
      return known(k) ? SHW_CLS_PROTO : SHW_CLS_UNKNOWN;
   endfunction
   // header octets look like kinds so a wrong skip shows up
   task automatic start_msg();
      msg.delete();
      repeat (MH) msg.push_back(8'h15);
   endtask
   task automatic add_sub(input logic [7:0] k, input logic [7:0] f, input logic [15:0] n,
      input int body);
      msg.push_back(k);
      msg.push_back(f);
      msg.push_back(f[0] ? n[7:0] : n[15:8]);
      msg.push_back(f[0] ? n[15:8] : n[7:0]);
      for (int i = 0; i < body; i++) msg.push_back(8'(i) ^ 8'h5a);
   endtask
   task automatic run_msg();
      int p, rem, bl, n, total;
      logic [7:0] k, f;
      logic [15:0] len;
      logic bad, last;
      total = msg.size();
      p = MH;
      bad = 1'b0;
      last = 1'b0;
      want_q.delete();
      got.delete();
      while (!last && !bad && p + 4 <= total) begin
         k = msg[p];
         f = msg[p+1];
         len = f[0] ? {msg[p+3], msg[p+2]} : {msg[p+2], msg[p+3]};
         rem = total - p - 4;
         bad = (len > rem);
         bl = (len == 0 && !(k == 8'h01 || k == 8'h09)) ? rem : int'(len);
         last = (bl == rem);
         if (!bad) want_q.push_back({3'h0, k, f & fmask(k), f[0], kcls(k), known(k), len,
            20'(p + 4), 20'(bl), last});
         p = p + 4 + bl;
      end
      foreach (msg[i]) src.push(msg[i]);
      msg_len = 20'(total);
      msg_start = 1'b1;
      @(negedge clk);
      msg_start = 1'b0;
      if (freeze) begin
         clk_en = 1'b0;
         repeat (3) @(negedge clk);
         clk_en = 1'b1;
      end
      n = 0;
      while (msg_done !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         fails++;
         end_of_test();
      end else begin
         @(negedge clk);
         check(80'(msg_done), 80'h0, "done pulse width");
         check(80'(malformed), 80'(bad), "malformed");
         check(80'(octet_ready), 80'h0, "ready after done");
         check(80'(got.size()), 80'(want_q.size()), "header count");
         foreach (want_q[i]) if (i < got.size()) check(got[i], want_q[i], "header");
         @(negedge clk);
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_reset();
      check(80'({octet_ready, sub_valid, malformed, msg_done}), 80'h0, "idle");
   endtask
   // every kind once, unused flag bits set except on 0x16, zero-length pad and timestamp mid-message
   task automatic s_all_kinds();
      logic [7:0] kinds [21] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d,
         8'h0e, 8'h0f, 8'h12, 8'h13, 8'h15, 8'h16, 8'h02, 8'h2f, 8'h30, 8'h3f, 8'h7f,
         8'h80, 8'hff};
      logic z;
      start_msg();
      foreach (kinds[i]) begin
         z = (kinds[i] == 8'h01 || kinds[i] == 8'h09);
         add_sub(kinds[i], kinds[i] == 8'h16 ? 8'h01 : {7'h7f, i[0]}, z ? 16'h0 : 16'h2,
            z ? 0 : 2);
      end
      add_sub(8'h81, 8'h01, 16'h0102, 258);
      add_sub(8'h15, 8'h00, 16'h0000, 3);
      run_msg();
   endtask
   task automatic s_exact_end();
      start_msg();
      add_sub(8'h07, 8'h00, 16'h3, 3);
      add_sub(8'h09, 8'h01, 16'h0, 0);
      run_msg();
      start_msg();
      add_sub(8'h08, 8'h00, 16'h5, 5);
      run_msg();
   endtask
   task automatic s_overrun();
      start_msg();
      add_sub(8'h07, 8'h01, 16'h2, 2);
      add_sub(8'h15, 8'h00, 16'ha, 6);
      run_msg();
      start_msg();
      add_sub(8'h0c, 8'h00, 16'h1, 1);
      run_msg();
   endtask
   // stalls hit mid-field and the clock enable freezes the header skip
   task automatic s_stalls();
      slow = 1'b1;
      freeze = 1'b1;
      start_msg();
      add_sub(8'h12, 8'h01, 16'h4, 4);
      add_sub(8'h0e, 8'h00, 16'h0, 0);
      run_msg();
      slow = 1'b0;
      freeze = 1'b0;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      s_reset();
      s_all_kinds();
      s_exact_end();
      s_overrun();
      s_stalls();
      end_of_test();
   end
endmodule // shw_walker_bench
`default_nettype wire
